// ==== rtl/fcu_pkg.sv ====
// package: register map, command layout and encodings of the flag chain condition unit
`default_nettype none
package fcu_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 8;                     // byte address width of the register window
    localparam int unsigned DATA_W = 32;                    // bus and operand width

    // register byte offsets
    localparam logic [7:0] DEST_OFF   = 8'h00;              // destination operand, takes the difference
    localparam logic [7:0] SRC_OFF    = 8'h04;              // source operand, or tested bit index
    localparam logic [7:0] CMD_OFF    = 8'h08;              // command; a write runs one instruction
    localparam logic [7:0] FLAGS_OFF  = 8'h0C;              // carry in bit 0, zero in bit 1
    localparam logic [7:0] STATUS_OFF = 8'h10;              // outcome of the last command

    // field positions inside the flags and status words
    localparam int unsigned FLAG_C_POS = 0;                 // carry flag bit
    localparam int unsigned FLAG_Z_POS = 1;                 // zero flag bit
    localparam int unsigned STAT_EX_POS = 0;                // last command executed
    localparam int unsigned STAT_DS_POS = 1;                // last command discarded

    // reset values
    localparam logic [31:0] DEST_RST = 32'h0000_0000;       // destination after reset
    localparam logic [31:0] SRC_RST  = 32'h0000_0000;       // source after reset
    localparam logic [31:0] CMD_RST  = 32'h0000_F000;       // no-op command, predicate field never passes
    localparam logic        FLAG_RST = 1'b0;                // carry and zero after reset

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;              // access done
    localparam logic [1:0] RESP_SLVERR = 2'h2;              // unmapped offset, or a write to the read-only status

    // four-bit truth tables indexed by {carry, zero}; used for predicates and modifiers
    localparam logic [3:0] PRED_ALWAYS              = 4'hF; // no predicate: always execute
    localparam logic [3:0] PRED_EQUAL               = 4'hA; // zero set
    localparam logic [3:0] PRED_WHEN_UNEQUAL        = 4'h5; // zero clear
    localparam logic [3:0] PRED_ABOVE               = 4'h1; // carry clear and zero clear
    localparam logic [3:0] PRED_WHEN_ABOVE_OR_EQUAL = 4'h3; // carry clear
    localparam logic [3:0] PRED_BELOW               = 4'hC; // carry set
    localparam logic [3:0] PRED_WHEN_BELOW_OR_EQUAL = 4'hE; // carry set or zero set
    localparam logic [3:0] MOD_FLAG_CLEAR_MODIFIER   = 4'h0; // constant zero
    localparam logic [3:0] MOD_GREATER_MODIFIER      = 4'h1; // not carry and not zero
    localparam logic [3:0] MOD_LESS_OR_EQUAL_MODIFIER = 4'hE; // carry or zero

    // instruction operations
    typedef enum logic [3:0] {
        OP_SUB             = 4'h0,                          // plain subtract
        OP_SUB_UNS_EXT     = 4'h1,                          // unsigned-extended subtract
        OP_SUB_SGN_EXT     = 4'h2,                          // signed-extended subtract
        OP_CMP             = 4'h3,                          // plain compare
        OP_CMP_UNS_EXT     = 4'h4,                          // unsigned-extended compare
        OP_CMP_SGN_EXT     = 4'h5,                          // signed-extended compare
        OP_TEST_BIT        = 4'h6,                          // test one bit of the destination
        OP_CARRY_MODIFY_OP = 4'h7,                          // modifier result into carry
        OP_ZERO_MODIFY_OP  = 4'h8,                          // modifier result into zero
        OP_FLAGS_MODIFY_OP = 4'h9                           // modifier result into both
    } fcu_op_e;

    // flag effects
    typedef enum logic [3:0] {
        FX_NONE             = 4'h0,                         // flags untouched
        FX_CARRY_WRITEBACK  = 4'h1,                         // write carry only
        FX_ZERO_WRITEBACK   = 4'h2,                         // write zero only
        FX_BOTH_WRITEBACK   = 4'h3,                         // write both flags
        FX_AND_INTO_CARRY   = 4'h4,                         // tested bit anded into carry
        FX_OR_INTO_CARRY    = 4'h5,                         // tested bit ored into carry
        FX_XOR_INTO_CARRY   = 4'h6,                         // tested bit xored into carry
        FX_AND_INTO_ZERO    = 4'h7,                         // tested bit anded into zero
        FX_OR_INTO_ZERO     = 4'h8,                         // tested bit ored into zero
        FX_XOR_INTO_ZERO    = 4'h9                          // tested bit xored into zero
    } fcu_fx_e;

    // command word layout
    typedef struct packed {
        logic [15:0] rsvd;                                  // reads back as written, unused
        logic [3:0]  modifier;                              // modifier truth table
        fcu_fx_e     effect;                                // flag effect
        logic [3:0]  predicate;                             // execution predicate truth table
        fcu_op_e     opcode;                                // operation
    } fcu_cmd_s;

    // the two flags travel together
    typedef struct packed {
        logic z;                                            // zero flag
        logic c;                                            // carry flag
    } fcu_flags_s;

endpackage
`default_nettype wire

// ==== rtl/fcu_flag_lut.sv ====
// evaluates a four-entry truth table of carry and zero
`timescale 1ns/1ps
`default_nettype none
module fcu_flag_lut (
    input  wire logic [3:0]         table_bits,
    input  wire fcu_pkg::fcu_flags_s flags,
    output logic                    hit
);
    import fcu_pkg::*;

    // entry {carry, zero} picks the answer
    assign hit = table_bits[{flags.c, flags.z}];
endmodule
`default_nettype wire

// ==== rtl/fcu_core.sv ====
// flag chain condition unit: extended subtract/compare flags, predicates, effects, flag modify
//
// Notes on behaviour
// - carry is borrow, last signed step gives sign
// - extended steps and their zero with incoming zero
// - compare sets flags like subtract, no writeback
// - compare chain: plain, unsigned-extended middles, extended top
// - extended steps use previous carry and zero
// - signed chain end: carry means less, zero equal
// - no predicate always runs, else flags decide
// - relational predicates map onto carry and zero
// - all single, and, or, equal, unequal flag tests
// - write suffix picks carry, zero, both or none
// - bit test may and, or, xor into flag
// - modify ops write modifier result per variant
// - comparison modifiers give the listed flag functions
// - logical modifiers cover every carry/zero combination
// - unsigned-extended chain end gives unsigned underflow
`timescale 1ns/1ps
`default_nettype none
module fcu_core (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic [fcu_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [fcu_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [fcu_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [fcu_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    import fcu_pkg::*;

    // architectural state
    logic [31:0] dest_reg;                                  // destination operand
    logic [31:0] src_reg;                                   // source operand
    fcu_cmd_s    cmd_reg;                                   // last command written
    fcu_flags_s  flags_reg;                                 // carry and zero
    logic [1:0]  status_reg;                                // executed / discarded of last command

    // write channel holding state
    logic        aw_hold_reg;                               // address taken, waiting for data
    logic [7:0]  awaddr_reg;                                // held write address
    logic        w_hold_reg;                                // data taken, waiting for address
    logic [31:0] wdata_reg;                                 // held write data
    logic [3:0]  wstrb_reg;                                 // held byte strobes
    logic        bvalid_reg;                                // write answer pending
    logic [1:0]  bresp_reg;                                 // write answer code
    logic        rvalid_reg;                                // read answer pending
    logic [31:0] rdata_reg;                                 // read data
    logic [1:0]  rresp_reg;                                 // read answer code

    // ---------------- bus slave decode ----------------
    wire aw_hs = s_axi_awvalid && s_axi_awready;            // address accepted this edge
    wire w_hs  = s_axi_wvalid && s_axi_wready;              // data accepted this edge
    wire aw_have = aw_hold_reg || aw_hs;                    // address available
    wire w_have  = w_hold_reg || w_hs;                      // data available
    wire wr_go = aw_have && w_have && !bvalid_reg;          // write completes at this edge
    wire [7:0]  wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]  wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_dest  = wr_go && (wr_addr == DEST_OFF);         // software write of destination
    wire wr_src   = wr_go && (wr_addr == SRC_OFF);          // software write of source
    wire wr_cmd   = wr_go && (wr_addr == CMD_OFF);          // command issue
    wire wr_flags = wr_go && (wr_addr == FLAGS_OFF);        // direct flag load
    wire wr_ok = wr_dest || wr_src || wr_cmd || wr_flags;   // mapped writable offset

    // handshake outputs
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // ---------------- instruction datapath ----------------
    wire fcu_cmd_s cmd_w = fcu_cmd_s'(wr_data);             // command as written
    wire exec_go = wr_cmd;                                  // one instruction per command write
    wire logic pass;                                        // predicate satisfied
    wire logic mod_val;                                     // modifier result

    // predicate: table 4'hF means no predicate, always runs
    fcu_flag_lut u_pred (
        .table_bits (cmd_w.predicate),
        .flags      (flags_reg),
        .hit        (pass)
    );

    // modifier: function of current carry and zero
    fcu_flag_lut u_mod (
        .table_bits (cmd_w.modifier),
        .flags      (flags_reg),
        .hit        (mod_val)
    );

    // operation class decode
    wire op_ext_u = (cmd_w.opcode == OP_SUB_UNS_EXT) || (cmd_w.opcode == OP_CMP_UNS_EXT);
    wire op_ext_s = (cmd_w.opcode == OP_SUB_SGN_EXT) || (cmd_w.opcode == OP_CMP_SGN_EXT);
    wire op_plain = (cmd_w.opcode == OP_SUB) || (cmd_w.opcode == OP_CMP);
    wire op_arith = op_plain || op_ext_u || op_ext_s;       // subtract or compare family
    wire op_sub   = (cmd_w.opcode == OP_SUB) || (cmd_w.opcode == OP_SUB_UNS_EXT)
                 || (cmd_w.opcode == OP_SUB_SGN_EXT);       // writes the difference
    wire op_test  = (cmd_w.opcode == OP_TEST_BIT);
    wire op_carry_modify_op  = (cmd_w.opcode == OP_CARRY_MODIFY_OP) || (cmd_w.opcode == OP_FLAGS_MODIFY_OP);
    wire op_zero_modify_op  = (cmd_w.opcode == OP_ZERO_MODIFY_OP) || (cmd_w.opcode == OP_FLAGS_MODIFY_OP);

    // extended steps borrow in the previous carry and chain the previous zero
    wire        cin = (op_ext_u || op_ext_s) && flags_reg.c;
    wire [32:0] diff_u = {1'b0, dest_reg} - {1'b0, src_reg} - {32'h0000_0000, cin};
    wire [32:0] diff_s = {dest_reg[31], dest_reg} - {src_reg[31], src_reg} - {32'h0000_0000, cin};
    wire        res_zero = (diff_u[31:0] == 32'h0000_0000);
    wire        ar_c = op_ext_s ? diff_s[32] : diff_u[32];
    wire        ar_z = (op_ext_u || op_ext_s) ? (res_zero && flags_reg.z) : res_zero;

    // tested bit, index from the source operand
    wire tbit = dest_reg[src_reg[4:0]];

    // plain suffix decode shared by the subtract, compare and bit test operations
    wire fx_wc = (cmd_w.effect == FX_CARRY_WRITEBACK) || (cmd_w.effect == FX_BOTH_WRITEBACK);
    wire fx_wz = (cmd_w.effect == FX_ZERO_WRITEBACK) || (cmd_w.effect == FX_BOTH_WRITEBACK);

    // carry and zero candidates and enables
    logic c_val;
    logic c_en;
    logic z_val;
    logic z_en;
    always_comb begin
        c_val = flags_reg.c;
        c_en  = 1'b0;
        z_val = flags_reg.z;
        z_en  = 1'b0;
        if (op_arith) begin
            // compare and subtract update flags the same way
            c_val = ar_c;
            c_en  = fx_wc;
            z_val = ar_z;
            z_en  = fx_wz;
        end else if (op_test) begin
            // overwrite one or both flags with the tested bit, or combine it into one flag
            c_en = fx_wc || (cmd_w.effect == FX_AND_INTO_CARRY) || (cmd_w.effect == FX_OR_INTO_CARRY)
                || (cmd_w.effect == FX_XOR_INTO_CARRY);
            z_en = fx_wz || (cmd_w.effect == FX_AND_INTO_ZERO) || (cmd_w.effect == FX_OR_INTO_ZERO)
                || (cmd_w.effect == FX_XOR_INTO_ZERO);
            case (cmd_w.effect)
                FX_AND_INTO_CARRY: c_val = flags_reg.c & tbit;
                FX_OR_INTO_CARRY:  c_val = flags_reg.c | tbit;
                FX_XOR_INTO_CARRY: c_val = flags_reg.c ^ tbit;
                default:           c_val = tbit;
            endcase
            case (cmd_w.effect)
                FX_AND_INTO_ZERO: z_val = flags_reg.z & tbit;
                FX_OR_INTO_ZERO:  z_val = flags_reg.z | tbit;
                FX_XOR_INTO_ZERO: z_val = flags_reg.z ^ tbit;
                default:          z_val = tbit;
            endcase
        end else begin
            // modify ops: variant picks the target flags
            c_val = mod_val;
            c_en  = op_carry_modify_op;
            z_val = mod_val;
            z_en  = op_zero_modify_op;
        end
    end

    // final enables: nothing moves unless the predicate passes
    wire c_we = exec_go && pass && c_en;
    wire z_we = exec_go && pass && z_en;
    wire d_we = exec_go && pass && op_sub;

    // read mux
    wire [31:0] flags_word = {30'h0000_0000, flags_reg.z, flags_reg.c};
    wire [31:0] status_word = {30'h0000_0000, status_reg};
    wire rd_hit = (s_axi_araddr == DEST_OFF) || (s_axi_araddr == SRC_OFF) || (s_axi_araddr == CMD_OFF)
               || (s_axi_araddr == FLAGS_OFF) || (s_axi_araddr == STATUS_OFF);
    wire [31:0] rd_word = (s_axi_araddr == DEST_OFF)  ? dest_reg :
                          (s_axi_araddr == SRC_OFF)   ? src_reg :
                          (s_axi_araddr == CMD_OFF)   ? 32'(cmd_reg) :
                          (s_axi_araddr == FLAGS_OFF) ? flags_word :
                          (s_axi_araddr == STATUS_OFF) ? status_word : 32'h0000_0000;

    // write channel bookkeeping
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
            w_hold_reg  <= 1'b0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            // hold whichever half came first
            aw_hold_reg <= aw_have && !wr_go;
            w_hold_reg  <= w_have && !wr_go;
            if (aw_hs) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            // answer after both halves
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // operand registers; the difference goes back to the destination
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dest_reg <= DEST_RST;
            src_reg  <= SRC_RST;
            cmd_reg  <= fcu_cmd_s'(CMD_RST);
        end else begin
            if (d_we) begin
                dest_reg <= diff_u[31:0];
            end else if (wr_dest) begin
                dest_reg <= (dest_reg & ~strb_mask) | (wr_data & strb_mask);
            end
            if (wr_src) begin
                src_reg <= (src_reg & ~strb_mask) | (wr_data & strb_mask);
            end
            if (wr_cmd) begin
                cmd_reg <= cmd_w;
            end
        end
    end

    // flags and outcome
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg  <= '{z: FLAG_RST, c: FLAG_RST};
            status_reg <= 2'h0;
        end else begin
            if (wr_flags && wr_strb[0]) begin
                flags_reg.c <= wr_data[FLAG_C_POS];
                flags_reg.z <= wr_data[FLAG_Z_POS];
            end
            if (c_we) begin
                flags_reg.c <= c_val;
            end
            if (z_we) begin
                flags_reg.z <= z_val;
            end
            if (exec_go) begin
                status_reg[STAT_EX_POS] <= pass;
                status_reg[STAT_DS_POS] <= !pass;
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // reference values computed independently of the datapath
    wire ref_ult = (dest_reg < src_reg) || ((dest_reg == src_reg) && flags_reg.c);
    wire ref_slt = ($signed(dest_reg) < $signed(src_reg)) || ((dest_reg == src_reg) && flags_reg.c);
    wire ref_z   = flags_reg.z && ((dest_reg - src_reg - {31'h0000_0000, flags_reg.c}) == 32'h0000_0000);
    wire cmd_any = exec_go && pass && (cmd_w.effect == FX_BOTH_WRITEBACK);

    sequence s_issue_skip;
        exec_go && !pass;
    endsequence
    sequence s_state_kept;
        $stable(flags_reg) && $stable(dest_reg);
    endsequence

    a_skip_keeps_all: assert property (s_issue_skip |=> s_state_kept)
        else $error("discarded instruction changed state");
    a_cmp_no_write: assert property (exec_go && pass && (cmd_w.opcode inside {OP_CMP, OP_CMP_UNS_EXT,
        OP_CMP_SGN_EXT}) |=> $stable(dest_reg))
        else $error("compare wrote the destination");
    a_uext_borrow: assert property (cmd_any && op_ext_u |=> flags_reg.c == $past(ref_ult))
        else $error("unsigned extended carry wrong");
    a_sext_less: assert property (cmd_any && op_ext_s |=> flags_reg.c == $past(ref_slt))
        else $error("signed extended carry wrong");
    a_zero_chain: assert property (cmd_any && (op_ext_u || op_ext_s) |=> flags_reg.z == $past(ref_z))
        else $error("zero chain wrong");
    a_pred_below_eq: assert property (exec_go && cmd_w.predicate == PRED_WHEN_BELOW_OR_EQUAL
        |-> pass == (flags_reg.c || flags_reg.z))
        else $error("below or equal predicate wrong");
    a_pred_always: assert property (exec_go && cmd_w.predicate == PRED_ALWAYS |-> pass)
        else $error("unpredicated instruction discarded");
    a_carry_only: assert property (exec_go && op_arith && cmd_w.effect == FX_CARRY_WRITEBACK
        |=> $stable(flags_reg.z))
        else $error("carry suffix touched zero");
    a_no_suffix: assert property (exec_go && op_arith && cmd_w.effect == FX_NONE |=> $stable(flags_reg))
        else $error("flags moved without suffix");
    a_mod_greater: assert property (exec_go && pass && cmd_w.opcode == OP_ZERO_MODIFY_OP
        && cmd_w.modifier == MOD_GREATER_MODIFIER
        |=> flags_reg.z == !($past(flags_reg.c) || $past(flags_reg.z)) && $stable(flags_reg.c))
        else $error("greater modifier into zero wrong");
    a_test_xor: assert property (exec_go && pass && op_test && cmd_w.effect == FX_XOR_INTO_CARRY
        |=> flags_reg.c == ($past(flags_reg.c) ^ $past(tbit)))
        else $error("xor into carry wrong");
    a_write_answer: assert property (wr_go |=> s_axi_bvalid)
        else $error("write not answered");
endmodule
`default_nettype wire

// ==== verif/fcu_seq_model.sv ====
// bus master model standing in for the decoder and sequencer
`timescale 1ns/1ps
`default_nettype none
module fcu_seq_model (
    input  wire logic        sys_clk,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic [31:0] s_axi_rdata,
    output logic             s_axi_awvalid,
    output logic             s_axi_wvalid,
    output logic             s_axi_bready,
    output logic             s_axi_arvalid,
    output logic             s_axi_rready,
    output logic             hung,
    output logic [7:0]       s_axi_awaddr,
    output logic [7:0]       s_axi_araddr,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb
);
    // all requests idle at time zero
    initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hung} = '0;
    // one write: both halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 7'h7F};
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        hung <= (n == 64);
    endtask
    // one read: address dropped once taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        hung <= (n == 64);
    endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking random bench for the flag chain condition unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fcu_pkg::*;
    logic sys_clk, rst_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hung;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, f;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] s_axi_rdata, s_axi_wdata, d, s, q, cmd;
    logic [35:0] e;                                     // expected {dest, status, z, c}
    int          n_mismatch = 0, n_checks = 0, i;
    fcu_core dut (.*);
    fcu_seq_model m (.*);
    // expected outcome of one instruction from the old state
    function automatic logic [35:0] model(logic [31:0] d, s, cmd, logic c, z);
        logic [32:0] t;
        logic [3:0]  fx;
        logic        b;
        fx = cmd[11:8];
        b = d[s[4:0]];
        t = (cmd[3:0] % 3 == 2) ? {d[31], d} - {s[31], s} - c : {1'b0, d} - {1'b0, s} - (cmd[3:0] % 3 != 0 && c);
        if (!cmd[4 + {c, z}]) return {d, 2'b10, z, c};
        case (cmd[3:0]) inside
            [0:5]: return {cmd[3:0] < 3 ? t[31:0] : d, 2'b01,
                (fx == 2 || fx == 3) ? (t[31:0] == 0 && (cmd[3:0] % 3 == 0 || z)) : z,
                (fx == 1 || fx == 3) ? t[32] : c};
            6: return {d, 2'b01, (fx == 2 || fx == 3) ? b : fx == 7 ? z & b : fx == 8 ? z | b : fx == 9 ? z ^ b : z,
                (fx == 1 || fx == 3) ? b : fx == 4 ? c & b : fx == 5 ? c | b : fx == 6 ? c ^ b : c};
            7, 8, 9: return {d, 2'b01, cmd[3:0] != 7 ? cmd[12 + {c, z}] : z, cmd[3:0] != 8 ? cmd[12 + {c, z}] : c};
            default: return {d, 2'b01, z, c};
        endcase
    endfunction
    // compares one read word or response
    task automatic cmp(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // prints the counts and the verdict
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // a bus wait that ran out ends the run
    always @(posedge hung) begin
        n_mismatch++;
        conclude();
    end
    // free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // reset, map checks, then random instruction stream
    initial begin
        rst_n = 1'b0;
        void'($urandom(24310));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        m.rd(FLAGS_OFF, q, r);
        cmp(q, 32'h0);
        m.rd(8'h14, q, r);
        cmp({q[29:0], r}, {30'h0, RESP_SLVERR});
        m.wr(STATUS_OFF, 32'h1, r);
        cmp({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test map done");
        f = 2'h0;
        for (i = 0; i < 300; i++) begin
            d = (i % 4 == 0) ? $urandom % 3 : $urandom;
            s = (i % 4 == 0) ? $urandom % 3 : $urandom;
            cmd = $urandom;
            cmd[3:0] = 4'($urandom % 10);
            cmd[11:8] = 4'($urandom % 10);
            if (i % 2 == 1) cmd[7:4] = PRED_ALWAYS;
            if (i % 20 == 5) cmd[15:0] = 16'h10F8;
            if (i % 20 == 15) cmd[3:0] = 4'hC;
            if (i % 8 == 0) f = 2'($urandom);
            if (i % 8 == 0) m.wr(FLAGS_OFF, {30'h0, f}, r);
            m.wr(DEST_OFF, d, r);
            m.wr(SRC_OFF, s, r);
            m.wr(CMD_OFF, cmd, r);
            e = model(d, s, cmd, f[0], f[1]);
            m.rd(DEST_OFF, q, r);
            cmp(q, e[35:4]);
            m.rd(FLAGS_OFF, q, r);
            cmp(q, {30'h0, e[1:0]});
            m.rd(STATUS_OFF, q, r);
            cmp(q, {30'h0, e[3:2]});
            f = e[1:0];
        end
        $display("test random done");
        conclude();
    end
endmodule
`default_nettype wire
